// [mpio_regs.svh]
// Purpose: address map, field positions and reset values of the port block
// Assumes: AXI4-Lite byte addresses, 12 bits decoded
// Notes:   address bits [11:6] pick a group, bits [5:2] pick the port, or the word in the misc group
`ifndef MPIO_REGS_SVH
`define MPIO_REGS_SVH
// group codes on address bits [11:6]
`define MPIO_GRP_DATA   6'h00
`define MPIO_GRP_DIR    6'h01
`define MPIO_GRP_PULL   6'h02
`define MPIO_GRP_FUNC   6'h03
`define MPIO_GRP_MISC   6'h04
// word index inside the misc group
`define MPIO_IDX_STAT   4'h0
`define MPIO_IDX_MASK   4'h1
`define MPIO_IDX_BITOP  4'h2
// bit-write command fields
`define MPIO_BITOP_PORT_LSB 0
`define MPIO_BITOP_BIT_LSB  4
`define MPIO_BITOP_VAL_POS  7
// port count and reset values
`define MPIO_NUM_PORTS  10
`define MPIO_DIR_RST    8'hFF
`define MPIO_MASK_RST   1'b1
`endif

// [mpio_pkg.sv]
// Purpose: types shared by the port block
// Assumes: ports are at most eight bits wide
// Notes:   state of each module is one packed struct
package mpio_pkg;
	typedef logic [7:0]      mpio_byte_t;
	typedef logic [31:0]     mpio_word_t;
	typedef logic [9:0][7:0] mpio_ports_t;
	typedef enum logic [1:0] {MPIO_OKAY = 2'h0, MPIO_SLVERR = 2'h2} mpio_resp_t;
	// state of the core: registers and bus slave
	typedef struct packed {
		mpio_ports_t latch;
		mpio_ports_t dir;
		mpio_ports_t pull;
		mpio_ports_t func;
		logic [3:0]  prevP0;
		logic        flag;
		logic        mask;
		logic        intReq;
		logic        awRdy;
		logic        wRdy;
		logic        arRdy;
		logic        awHave;
		logic        wHave;
		logic        bValid;
		logic        rValid;
		logic [11:0] awAddr;
		mpio_word_t  wData;
		logic        wLane;
		mpio_resp_t  bResp;
		mpio_resp_t  rResp;
		mpio_word_t  rData;
	} mpio_core_st_t;
	// state of one port slice
	typedef struct packed {
		mpio_byte_t sync1;
		mpio_byte_t sync2;
		mpio_byte_t out;
		mpio_byte_t oe;
		mpio_byte_t pull;
	} mpio_pin_st_t;
endpackage

// [mpio_port_if.sv]
// Purpose: control and readback between the core and one port slice
// Assumes: one clock domain
// Notes:   core drives settings, slice returns synchronised pin levels
interface mpio_port_if;
	logic [7:0] latch;
	logic [7:0] dir;
	logic [7:0] pullSel;
	logic [7:0] funcSel;
	logic [7:0] segIn;
	logic [7:0] pinSync;
	modport core (output latch, dir, pullSel, funcSel, segIn, input pinSync);
	modport port (input latch, dir, pullSel, funcSel, segIn, output pinSync);
endinterface

// [mpio_port.sv]
// Purpose: pin driver, pull-up and input synchroniser of one port
// Assumes: masks give the bits that can drive, pull up or carry segments
// Notes:   all pin outputs are registered
module mpio_port #(
	parameter mpio_pkg::mpio_byte_t DRV  = 8'hFF,
	parameter mpio_pkg::mpio_byte_t PUOK = 8'hFF,
	parameter mpio_pkg::mpio_byte_t PFOK = 8'h00
) (
	mpio_port_if.port        pif,
	input  logic             core_clk,
	input  logic             arst_n,
	input  mpio_pkg::mpio_byte_t pinIn,
	output mpio_pkg::mpio_byte_t pinOut,
	output mpio_pkg::mpio_byte_t pinOe,
	output mpio_pkg::mpio_byte_t pullupEn
);
	import mpio_pkg::*;

	mpio_pin_st_t s_q;
	mpio_pin_st_t s_d;
	mpio_byte_t   seg;

	// next pin state from the settings
	always_comb begin
		s_d = s_q;
		s_d.sync1 = pinIn;
		s_d.sync2 = s_q.sync1;
		seg = PFOK & pif.funcSel;
		s_d.oe = DRV & (~pif.dir | seg);
		s_d.out = s_d.oe & ((seg & pif.segIn) | (~seg & pif.latch));
		s_d.pull = PUOK & pif.dir & pif.pullSel & ~s_d.oe;
	end

	// state register, pins released at reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// registered pin outputs and the synchronised pin level
	assign pif.pinSync = s_q.sync2;
	assign pinOut      = s_q.out;
	assign pinOe       = s_q.oe;
	assign pullupEn    = s_q.pull;

	// a pull-up never fights the driver, and bits without a driver never drive
	pullNotDriven_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pullupEn & pinOe) == 8'h00) else $error("pull-up on a driven pin");
	noDriveMask_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pinOe & ~DRV) == 8'h00) else $error("drive on a bit without driver");
endmodule

// [mpio_top.sv]
// Purpose: parallel ports with direction, pull-up and segment control
// Assumes: AXI4-Lite slave, 20 MHz core_clk, pins sampled by two flops
// Notes:   ports 0 to 9, port 7 absent; port 1 input only
//
// Summary of operation
// - port 3, four bits, per-bit direction
// - input bit pull-up follows its select bit
// - ports 4, 8, 9: eight bidirectional bits
// - reset leaves bidirectional ports as inputs
// - reset loads all direction registers with ones
// - port 5 outputs float while direction one
// - reset floats all port 5 pins
// - port 5 reads latch only when direction one
// - port 6 six bits, pull-ups bits 2-5
// - port 6 bits 0 and 1 never pull up
// - pull-up and function registers per listed port
// - direction registers take bit and byte writes
// - port 1 bits are input only
// - port 0 output change sets interrupt flag
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
module mpio_top (
	input  logic                  core_clk,
	input  logic                  arst_n,
	input  logic [11:0]           s_axi_awaddr,
	input  logic                  s_axi_awvalid,
	output logic                  s_axi_awready,
	input  mpio_pkg::mpio_word_t  s_axi_wdata,
	input  logic [3:0]            s_axi_wstrb,
	input  logic                  s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  logic                  s_axi_bready,
	input  logic [11:0]           s_axi_araddr,
	input  logic                  s_axi_arvalid,
	output logic                  s_axi_arready,
	output mpio_pkg::mpio_word_t  s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  logic                  s_axi_rready,
	input  mpio_pkg::mpio_ports_t pinIn,
	input  mpio_pkg::mpio_ports_t segIn,
	output wire mpio_pkg::mpio_ports_t pinOut,
	output wire mpio_pkg::mpio_ports_t pinOe,
	output wire mpio_pkg::mpio_ports_t pullupEn,
	output logic                  extIntReq
);
	import mpio_pkg::*;
	`include "mpio_regs.svh"

	// bits that have an output driver
	function automatic mpio_byte_t drvMask(input logic [3:0] p);
		case (p)
			4'h0:    drvMask = 8'h0F;
			4'h3:    drvMask = 8'hF0;
			4'h6:    drvMask = 8'h3F;
			4'h2, 4'h4, 4'h5, 4'h8, 4'h9: drvMask = 8'hFF;
			default: drvMask = 8'h00;
		endcase
	endfunction

	// bits that exist at all
	function automatic mpio_byte_t presMask(input logic [3:0] p);
		presMask = drvMask(p) | ((p == 4'h1) ? 8'h1F : 8'h00);
	endfunction

	// bits with a selectable pull-up
	function automatic mpio_byte_t puMask(input logic [3:0] p);
		case (p)
			4'h0:    puMask = 8'h0F;
			4'h3:    puMask = 8'hF0;
			4'h6:    puMask = 8'h3C;
			4'h4, 4'h8, 4'h9: puMask = 8'hFF;
			default: puMask = 8'h00;
		endcase
	endfunction

	// bits with a segment function select
	function automatic mpio_byte_t pfMask(input logic [3:0] p);
		case (p)
			4'h3:    pfMask = 8'hF0;
			4'h4, 4'h8, 4'h9: pfMask = 8'hFF;
			default: pfMask = 8'h00;
		endcase
	endfunction

	// output-only ports with latch readback
	function automatic logic outOnly(input logic [3:0] p);
		outOnly = (p == 4'h2) || (p == 4'h5);
	endfunction

	mpio_core_st_t s_q;
	mpio_core_st_t s_d;
	mpio_ports_t   syncArr;

	// one slice per port
	for (genvar p = 0; p < `MPIO_NUM_PORTS; p++) begin : gPort
		mpio_port_if pif ();
		assign pif.latch   = s_q.latch[p];
		assign pif.dir     = s_q.dir[p];
		assign pif.pullSel = s_q.pull[p];
		assign pif.funcSel = s_q.func[p];
		assign pif.segIn   = segIn[p];
		assign syncArr[p]  = pif.pinSync;
		mpio_port #(
			.DRV  (drvMask(4'(p))),
			.PUOK (outOnly(4'(p)) ? 8'h00 : puMask(4'(p))),
			.PFOK (pfMask(4'(p)))
		) uPort (
			.pif      (pif),
			.core_clk (core_clk),
			.arst_n   (arst_n),
			.pinIn    (pinIn[p]),
			.pinOut   (pinOut[p]),
			.pinOe    (pinOe[p]),
			.pullupEn (pullupEn[p])
		);
	end

	logic [5:0] wGrp;
	logic [3:0] wIdx;
	logic [5:0] rGrp;
	logic [3:0] rIdx;
	logic       wOk;
	logic       rOk;
	logic       clrFlag;
	logic [3:0] chg;
	logic [3:0] bPort;
	logic [2:0] bBit;
	mpio_byte_t rByte;

	// bus slave, register file and interrupt flag
	always_comb begin
		s_d = s_q;
		wGrp = s_q.awAddr[11:6];
		wIdx = s_q.awAddr[5:2];
		rGrp = s_axi_araddr[11:6];
		rIdx = s_axi_araddr[5:2];
		wOk = 1'b0;
		rOk = 1'b0;
		clrFlag = 1'b0;
		rByte = 8'h00;
		bPort = s_q.wData[`MPIO_BITOP_PORT_LSB +: 4];
		bBit = s_q.wData[`MPIO_BITOP_BIT_LSB +: 3];
		// response handshakes
		if (s_q.bValid && s_axi_bready) begin
			s_d.bValid = 1'b0;
		end
		if (s_q.rValid && s_axi_rready) begin
			s_d.rValid = 1'b0;
		end
		// write once address and data are both held
		if (s_q.awHave && s_q.wHave && !s_q.bValid) begin
			case (wGrp)
				`MPIO_GRP_DATA: wOk = (presMask(wIdx) != 8'h00);
				`MPIO_GRP_DIR:  wOk = (drvMask(wIdx) != 8'h00);
				`MPIO_GRP_PULL: wOk = (puMask(wIdx) != 8'h00);
				`MPIO_GRP_FUNC: wOk = (pfMask(wIdx) != 8'h00);
				`MPIO_GRP_MISC: wOk = (wIdx <= `MPIO_IDX_BITOP);
				default:        wOk = 1'b0;
			endcase
			if (wOk && s_q.wLane) begin
				case (wGrp)
					`MPIO_GRP_DATA: s_d.latch[wIdx] = s_q.wData[7:0] & drvMask(wIdx);
					`MPIO_GRP_DIR:  s_d.dir[wIdx] = s_q.wData[7:0];
					`MPIO_GRP_PULL: s_d.pull[wIdx] = s_q.wData[7:0] & puMask(wIdx);
					`MPIO_GRP_FUNC: s_d.func[wIdx] = s_q.wData[7:0] & pfMask(wIdx);
					default: begin
						if (wIdx == `MPIO_IDX_STAT) begin
							clrFlag = s_q.wData[0];
						end else if (wIdx == `MPIO_IDX_MASK) begin
							s_d.mask = s_q.wData[0];
						end else if (drvMask(bPort) != 8'h00) begin
							s_d.dir[bPort][bBit] = s_q.wData[`MPIO_BITOP_VAL_POS];
						end
					end
				endcase
			end
			s_d.bResp = wOk ? MPIO_OKAY : MPIO_SLVERR;
			s_d.bValid = 1'b1;
			s_d.awHave = 1'b0;
			s_d.wHave = 1'b0;
		end
		// take write address and data, in either order
		if (s_axi_awvalid && s_q.awRdy) begin
			s_d.awHave = 1'b1;
			s_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wRdy) begin
			s_d.wHave = 1'b1;
			s_d.wData = s_axi_wdata;
			s_d.wLane = s_axi_wstrb[0];
		end
		// read decode
		if (rIdx < 4'(`MPIO_NUM_PORTS)) begin
			case (rGrp)
				`MPIO_GRP_DATA: begin
					rOk = (presMask(rIdx) != 8'h00);
					if (outOnly(rIdx)) begin
						rByte = s_q.latch[rIdx] & s_q.dir[rIdx];
					end else begin
						rByte = presMask(rIdx) & ((drvMask(rIdx) & ~s_q.dir[rIdx]
							& s_q.latch[rIdx]) | ((s_q.dir[rIdx] | ~drvMask(rIdx))
							& syncArr[rIdx]));
					end
				end
				`MPIO_GRP_DIR: begin
					rOk = (drvMask(rIdx) != 8'h00);
					rByte = s_q.dir[rIdx];
				end
				`MPIO_GRP_PULL: begin
					rOk = (puMask(rIdx) != 8'h00);
					rByte = s_q.pull[rIdx];
				end
				`MPIO_GRP_FUNC: begin
					rOk = (pfMask(rIdx) != 8'h00);
					rByte = s_q.func[rIdx];
				end
				`MPIO_GRP_MISC: begin
					rOk = (rIdx <= `MPIO_IDX_BITOP);
					rByte = {7'h00, (rIdx == `MPIO_IDX_STAT) ? s_q.flag
						: ((rIdx == `MPIO_IDX_MASK) && s_q.mask)};
				end
				default: rOk = 1'b0;
			endcase
		end
		if (s_axi_arvalid && s_q.arRdy) begin
			s_d.rValid = 1'b1;
			s_d.rData = {24'h00_0000, rOk ? rByte : 8'h00};
			s_d.rResp = rOk ? MPIO_OKAY : MPIO_SLVERR;
		end
		// port 0 level change while driving sets the flag, set beats clear
		chg = (syncArr[0][3:0] ^ s_q.prevP0) & ~s_q.dir[0][3:0];
		s_d.prevP0 = syncArr[0][3:0];
		s_d.flag = (s_q.flag & ~clrFlag) | (|chg);
		s_d.intReq = s_d.flag & ~s_d.mask;
		s_d.awRdy = !s_d.awHave && !s_d.bValid;
		s_d.wRdy = !s_d.wHave && !s_d.bValid;
		s_d.arRdy = !s_d.rValid;
	end

	// state register with reset values
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.dir <= {`MPIO_NUM_PORTS{`MPIO_DIR_RST}};
			s_q.mask <= `MPIO_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// bus and interrupt outputs straight from the state register
	assign s_axi_awready = s_q.awRdy;
	assign s_axi_wready  = s_q.wRdy;
	assign s_axi_bvalid  = s_q.bValid;
	assign s_axi_bresp   = s_q.bResp;
	assign s_axi_arready = s_q.arRdy;
	assign s_axi_rvalid  = s_q.rValid;
	assign s_axi_rdata   = s_q.rData;
	assign s_axi_rresp   = s_q.rResp;
	assign extIntReq     = s_q.intReq;

	// checks on reset, pin drive, readback, interrupt flag and bus answers
	dirReset_a: assert property (@(posedge core_clk) $rose(arst_n) |->
		(s_q.dir == {`MPIO_NUM_PORTS{8'hFF}}) && (pinOe == '0))
		else $error("direction not all ones after reset");
	inputAfterReset_a: assert property (@(posedge core_clk) $rose(arst_n) |->
		##1 (pinOe == '0)) else $error("pin driven after reset");
	p5Float_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(s_q.dir[5] == 8'hFF) |=> (pinOe[5] == 8'h00))
		else $error("port 5 driven while direction is one");
	p3Drive_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!s_q.dir[3][4] && !s_q.func[3][4]) |=>
		(pinOe[3][4] && pinOut[3][4] == $past(s_q.latch[3][4])))
		else $error("port 3 bit 4 not driving latch");
	p6NoPull_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		pullupEn[6][1:0] == 2'h0) else $error("port 6 low bits pulled up");
	p1Input_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		pinOe[1] == 8'h00) else $error("port 1 driven");
	p5Readback_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h014) |=>
		(s_axi_rvalid && s_axi_rdata[7:0] == $past(s_q.latch[5] & s_q.dir[5])))
		else $error("port 5 readback wrong");
	flagSet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(|chg) |=> s_q.flag ##0 (extIntReq == !s_q.mask))
		else $error("port 0 change did not raise flag");
	writeResp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(s_q.awHave && s_q.wHave && !s_q.bValid) |=> s_axi_bvalid ##0
		(($past(s_q.awAddr) != 12'h04C) || !$past(s_q.wLane)
		|| (s_q.dir[3] == $past(s_q.wData[7:0]))))
		else $error("write not answered or direction byte lost");

	// main scenarios reached
	writeSeen_c: cover property (@(posedge core_clk) disable iff (!arst_n)
		s_axi_bvalid && s_axi_bready);
	readSeen_c: cover property (@(posedge core_clk) disable iff (!arst_n)
		s_axi_rvalid && s_axi_rready);
	flagSeen_c: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(s_q.flag));
	segSeen_c: cover property (@(posedge core_clk) disable iff (!arst_n)
		(s_q.func[4] != 8'h00) && (pinOe[4] != 8'h00));
endmodule

// [mpio_pin_model.sv]
// Purpose: pin-side model that resolves the level seen on every port pin
// Assumes: device drive wins, then the bench's external drive, then pull-up
// Notes:   an undriven pin without pull-up toggles every cycle
module mpio_pin_model (
	input  wire logic                  core_clk,
	input  wire mpio_pkg::mpio_ports_t pinOut,
	input  wire mpio_pkg::mpio_ports_t pinOe,
	input  wire mpio_pkg::mpio_ports_t pullupEn,
	input  wire mpio_pkg::mpio_ports_t extEn,
	input  wire mpio_pkg::mpio_ports_t extVal,
	output mpio_pkg::mpio_ports_t      pinIn
);
	timeunit 1ns;
	timeprecision 1ns;
	import mpio_pkg::*;
	logic flip_q = 1'b0;
	// changing pattern so a floating pin never reads as a stable level
	always @(posedge core_clk) begin
		flip_q <= !flip_q;
	end
	// wire level from all drivers on each pin
	always_comb begin
		for (int p = 0; p < 10; p++) begin
			for (int b = 0; b < 8; b++) begin
				pinIn[p][b] = pinOe[p][b] ? pinOut[p][b] : extEn[p][b] ? extVal[p][b] :
					pullupEn[p][b] ? 1'b1 : flip_q ^ b[0];
			end
		end
	end
endmodule

// [tb.sv]
// Purpose: register and pin checks of the port block over AXI4-Lite
// Assumes: pin model beside the block, 20 MHz core_clk
// Notes:   pin outputs are checked a few cycles after each change
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mpio_pkg::*;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        extIntReq;
	mpio_word_t  s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	mpio_ports_t pinIn, segIn = '0, extEn = '0, extVal = '0;
	wire mpio_ports_t pinOut, pinOe, pullupEn;
	int          errors = 0, comparisons = 0;
	int          dp[8] = '{0, 2, 3, 4, 5, 6, 8, 9};
	int          bp[3] = '{4, 8, 9};
	int          fp[4] = '{3, 4, 8, 9};
	always #25 core_clk = ~core_clk;
	mpio_top uut (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .segIn,
		.pinOut, .pinOe, .pullupEn, .extIntReq);
	mpio_pin_model pins_m (.core_clk, .pinOut, .pinOe, .pullupEn, .extEn, .extVal, .pinIn);
	// one value against its expectation
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// counts and verdict, then stop
	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic hang();
		errors++;
		$display("Error bus answer expected in time seen none");
		close_out();
	endtask
	// write with address and data offered together
	task automatic wr(input logic [11:0] a, input mpio_byte_t d, input logic [1:0] er = 2'h0);
		int n;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= 32'(d);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 40) begin
			hang();
		end else begin
			s_axi_bready <= 1'b0;
			cmp("bresp", 32'(er), 32'(s_axi_bresp));
		end
	endtask
	// read, checking the bits under mask m and the upper bits zero
	task automatic rd(input logic [11:0] a, input mpio_byte_t e, input mpio_byte_t m = 8'hFF,
		input logic [1:0] er = 2'h0);
		int n;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 40) begin
			hang();
		end else begin
			s_axi_rready <= 1'b0;
			cmp("rresp", 32'(er), 32'(s_axi_rresp));
			cmp("rdata", 32'(e), s_axi_rdata & {24'hFF_FFFF, m});
		end
	endtask
	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	// pin drive, level and pull-up of one port
	task automatic pins(input int p, input mpio_byte_t oe, input mpio_byte_t o, input mpio_byte_t pu);
		settle();
		cmp("pinOe", 32'(oe), 32'(pinOe[p]));
		cmp("pinOut", 32'(o), 32'(pinOut[p]));
		cmp("pullupEn", 32'(pu), 32'(pullupEn[p]));
	endtask
	// main sequence
	initial begin
		extEn[0] = 8'h01;
		extEn[1] = 8'h1F;
		extVal[1] = 8'h15;
		extEn[3] = 8'h10;
		segIn[8] = 8'h01;
		foreach (bp[i]) extEn[bp[i]] = 8'hFF;
		foreach (bp[i]) extVal[bp[i]] = 8'h96;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		foreach (dp[i]) rd(12'h040 + 12'(4 * dp[i]), 8'hFF);
		for (int p = 0; p < 10; p++) pins(p, 8'h00, 8'h00, 8'h00);
		$display("test reset done");
		wr(12'h04C, 8'h3F);
		wr(12'h00C, 8'h90);
		wr(12'h08C, 8'hFF);
		pins(3, 8'hC0, 8'h80, 8'h30);
		rd(12'h00C, 8'hA0, 8'hF0);
		wr(12'h108, 8'h53);
		rd(12'h04C, 8'h1F);
		pins(3, 8'hE0, 8'h80, 8'h10);
		wr(12'h108, 8'hE3);
		rd(12'h04C, 8'h5F);
		wr(12'h108, 8'h43);
		rd(12'h04C, 8'h4F);
		pins(3, 8'hB0, 8'h90, 8'h40);
		$display("test port3 done");
		foreach (bp[i]) begin
			wr(12'h040 + 12'(4 * bp[i]), 8'h55);
			wr(12'h000 + 12'(4 * bp[i]), 8'h0F);
			wr(12'h080 + 12'(4 * bp[i]), 8'hFF);
			pins(bp[i], 8'hAA, 8'h0A, 8'h55);
			rd(12'h000 + 12'(4 * bp[i]), 8'h1E);
		end
		$display("test ports 4 8 9 done");
		wr(12'h098, 8'hFF);
		pins(6, 8'h00, 8'h00, 8'h3C);
		wr(12'h058, 8'hF0);
		pins(6, 8'h0F, 8'h00, 8'h30);
		$display("test port6 done");
		wr(12'h014, 8'h5A);
		pins(5, 8'h00, 8'h00, 8'h00);
		rd(12'h014, 8'h5A);
		wr(12'h054, 8'h0F);
		pins(5, 8'hF0, 8'h50, 8'h00);
		rd(12'h014, 8'h0A);
		$display("test port5 done");
		wr(12'h004, 8'hFF);
		rd(12'h004, 8'h15, 8'h1F);
		pins(1, 8'h00, 8'h00, 8'h00);
		rd(12'h044, 8'h00, 8'hFF, 2'h2);
		wr(12'h200, 8'h01, 2'h2);
		rd(12'h200, 8'h00, 8'hFF, 2'h2);
		rd(12'h088, 8'h00, 8'hFF, 2'h2);
		rd(12'h0C0, 8'h00, 8'hFF, 2'h2);
		foreach (fp[i]) rd(12'h0C0 + 12'(4 * fp[i]), 8'h00);
		rd(12'h0A4, 8'hFF);
		$display("test map done");
		wr(12'h020, 8'h00);
		wr(12'h0E0, 8'h03);
		wr(12'h060, 8'hFF);
		rd(12'h0E0, 8'h03);
		s_axi_wstrb <= 4'h0;
		wr(12'h0E0, 8'hFF);
		s_axi_wstrb <= 4'h1;
		rd(12'h0E0, 8'h03);
		pins(8, 8'h03, 8'h01, 8'hFC);
		$display("test segment done");
		wr(12'h040, 8'hFE);
		wr(12'h000, 8'h01);
		settle();
		rd(12'h100, 8'h01);
		cmp("extIntReq", 32'h0000_0000, 32'(extIntReq));
		wr(12'h104, 8'h00);
		settle();
		cmp("extIntReq", 32'h0000_0001, 32'(extIntReq));
		wr(12'h100, 8'h01);
		rd(12'h100, 8'h00);
		settle();
		cmp("extIntReq", 32'h0000_0000, 32'(extIntReq));
		$display("test interrupt done");
		close_out();
	end
endmodule
